/* File: hdl/dcd_dev.sv */
`timescale 1ns/1ps
module dcd_dev (
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // CPU side bus.
  dcd_if.dev              bus,
  // FIFO fill side, used in the read direction.
  input  wire logic       usb_in_valid,
  input  wire logic [7:0] usb_in_data,
  output logic            usb_in_ready,
  // FIFO drain side, used in the write direction.
  output logic            usb_out_valid,
  output logic [7:0]      usb_out_data,
  input  wire logic       usb_out_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        free_run;
    logic        ack_reg;
    logic        dir;
    logic        running;
    logic        ovf;
    logic        cmp;
    logic [31:0] count;
    logic [7:0]  lvl_snap;
    logic [23:0] cnt_snap;
    logic [11:0] wp;
    logic [11:0] rp;
    logic [12:0] level;
    logic [15:0] rdata;
    logic        rvalid;
    logic        irq;
    logic        in_ready;
    logic        out_valid;
    logic [7:0]  out_data;
  } dcd_dev_s;

  dcd_dev_s   r_reg;
  dcd_dev_s   r_next;
  logic [7:0] mem [dcd_pkg::FIFO_DEPTH];

  logic        rd_acc;
  logic        wr_acc;
  logic        port_rd;
  logic        pin_acc;
  logic        go_xfer;
  logic [12:0] view;
  logic [1:0]  mv;
  logic        in_fire;
  logic        out_fire;
  logic [1:0]  push_n;
  logic [1:0]  pop_n;
  logic [32:0] sum;
  logic [7:0]  rbyte;

  // ----------------------------------------------------------------
  // Transfer decode
  // ----------------------------------------------------------------
  // Port reads move data only in the read direction and register mode.
  always_comb begin
    rd_acc  = bus.cs & bus.rd;
    wr_acc  = bus.cs & bus.wr;
    port_rd = rd_acc & r_reg.ack_reg & r_reg.dir &
              ((bus.addr == dcd_pkg::A_RD_EVEN) |
               (bus.addr == dcd_pkg::A_RD_ODD));
    pin_acc = bus.acknowledge_pin & ~r_reg.ack_reg;
    go_xfer = r_reg.running & (port_rd | pin_acc);
    // Level shows data held or room left by direction.
    if (r_reg.dir) begin
      view = r_reg.level;
    end else begin
      view = dcd_pkg::FIFO_FULL - r_reg.level;
    end
    // Bytes moved: one in 8-bit mode, two in 16-bit mode, clipped.
    mv = bus.bus8 ? 2'd1 : 2'd2;
    if ({11'h000, mv} > view) begin
      mv = view[1:0];
    end
    if (!r_reg.free_run && r_reg.count < {30'h0, mv}) begin
      mv = r_reg.count[1:0];
    end
    if (!go_xfer) begin
      mv = 2'd0;
    end
    in_fire  = usb_in_valid & r_reg.in_ready;
    out_fire = usb_out_ready & r_reg.out_valid;
    push_n   = r_reg.dir ? {1'b0, in_fire} : mv;
    pop_n    = r_reg.dir ? mv : {1'b0, out_fire};
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // High bytes snapshot the low bytes so a high-first read is coherent.
  always_comb begin
    if (bus.addr == dcd_pkg::A_CFG) begin
      rbyte = {r_reg.free_run, r_reg.ack_reg, 6'h00};
    end else if (bus.addr == dcd_pkg::A_CTRL) begin
      rbyte = {r_reg.running, 3'h0, r_reg.dir, 3'h0};
    end else if (bus.addr == dcd_pkg::A_LVL_H) begin
      rbyte = {3'h0, view[12:8]};
    end else if (bus.addr == dcd_pkg::A_LVL_L) begin
      rbyte = r_reg.lvl_snap;
    end else if (bus.addr == dcd_pkg::A_CNT3) begin
      rbyte = r_reg.count[31:24];
    end else if (bus.addr == dcd_pkg::A_CNT2) begin
      rbyte = r_reg.cnt_snap[23:16];
    end else if (bus.addr == dcd_pkg::A_CNT1) begin
      rbyte = r_reg.cnt_snap[15:8];
    end else if (bus.addr == dcd_pkg::A_CNT0) begin
      rbyte = r_reg.cnt_snap[7:0];
    end else if (bus.addr == dcd_pkg::A_ISTAT) begin
      rbyte = {6'h00, r_reg.ovf, r_reg.cmp};
    end else begin
      rbyte = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Writes first, then start and stop, then transfer events so a flag
  // set by an event wins over a clear in the same cycle.
  always_comb begin
    r_next        = r_reg;
    r_next.rvalid = 1'b0;
    sum           = 33'h0_0000_0000;
    if (rd_acc || (pin_acc && r_reg.dir)) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = {8'h00, rbyte};
    end
    if (rd_acc && bus.addr == dcd_pkg::A_LVL_H) begin
      r_next.lvl_snap = view[7:0];
    end
    if (rd_acc && bus.addr == dcd_pkg::A_CNT3) begin
      r_next.cnt_snap = r_reg.count[23:0];
    end
    if (wr_acc) begin
      if (bus.addr == dcd_pkg::A_CFG) begin
        r_next.free_run = bus.wdata[dcd_pkg::CFG_FREE];
        r_next.ack_reg  = bus.wdata[dcd_pkg::CFG_ACKREG];
      end else if (bus.addr == dcd_pkg::A_CTRL) begin
        r_next.dir = bus.wdata[dcd_pkg::CTL_DIR];
        if (bus.wdata[dcd_pkg::CTL_CLR] && !r_reg.running) begin
          r_next.count = dcd_pkg::CNT_RST;
        end
        if (bus.wdata[dcd_pkg::CTL_STOP]) begin
          r_next.running = 1'b0;
          r_next.cmp     = 1'b1;
        end else if (bus.wdata[dcd_pkg::CTL_GO]) begin
          r_next.running = 1'b1;
        end
      end else if (bus.addr == dcd_pkg::A_ISTAT) begin
        r_next.cmp = r_reg.cmp & ~bus.wdata[dcd_pkg::IST_CMP];
        r_next.ovf = r_reg.ovf & ~bus.wdata[dcd_pkg::IST_OVF];
      end else if (!r_reg.running) begin
        // Length is loaded while idle; any 32-bit value is legal.
        if (bus.addr == dcd_pkg::A_CNT3) begin
          r_next.count[31:24] = bus.wdata[7:0];
        end else if (bus.addr == dcd_pkg::A_CNT2) begin
          r_next.count[23:16] = bus.wdata[7:0];
        end else if (bus.addr == dcd_pkg::A_CNT1) begin
          r_next.count[15:8] = bus.wdata[7:0];
        end else if (bus.addr == dcd_pkg::A_CNT0) begin
          r_next.count[7:0] = bus.wdata[7:0];
        end
      end
    end
    // A zero length in count mode completes at once.
    if (r_next.running && !r_reg.running && !r_reg.free_run &&
        r_next.count == 32'h0000_0000) begin
      r_next.running = 1'b0;
      r_next.cmp     = 1'b1;
    end
    if (go_xfer && r_reg.dir) begin
      r_next.rdata[7:0]  = (mv != 2'd0) ? mem[r_reg.rp] : 8'h00;
      r_next.rdata[15:8] = (mv == 2'd2) ? mem[r_reg.rp + 12'h001]
                                        : 8'h00;
    end
    if (mv != 2'd0) begin
      if (r_reg.free_run) begin
        sum          = {1'b0, r_reg.count} + {31'h0, mv};
        r_next.count = sum[31:0];
        if (sum[32]) begin
          r_next.ovf = 1'b1;
        end
      end else begin
        r_next.count = r_reg.count - {30'h0, mv};
        if (r_next.count == 32'h0000_0000) begin
          r_next.running = 1'b0;
          r_next.cmp     = 1'b1;
        end
      end
    end
    r_next.wp        = r_reg.wp + {10'h000, push_n};
    r_next.rp        = r_reg.rp + {10'h000, pop_n};
    r_next.level     = r_reg.level + {11'h000, push_n} -
                       {11'h000, pop_n};
    r_next.in_ready  = r_next.dir & (r_next.level < dcd_pkg::FIFO_FULL);
    // Only bytes stored before this cycle count, so the read is settled.
    r_next.out_valid = ~r_next.dir &
                       ((r_reg.level - {11'h000, pop_n}) != 13'h0000);
    r_next.out_data  = mem[r_next.rp];
    r_next.irq       = r_next.ovf | r_next.cmp;
  end

  // ----------------------------------------------------------------
  // Registers and FIFO storage
  // ----------------------------------------------------------------
  // All control state resets to constants.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // FIFO storage is written by the USB side or by the bus side.
  always_ff @(posedge hclk) begin
    if (in_fire && r_reg.dir) begin
      mem[r_reg.wp] <= usb_in_data;
    end
    if (!r_reg.dir && mv != 2'd0) begin
      mem[r_reg.wp] <= bus.wdata[7:0];
    end
    if (!r_reg.dir && mv == 2'd2) begin
      mem[r_reg.wp + 12'h001] <= bus.wdata[15:8];
    end
  end

  // Outputs straight from flip-flops.
  assign bus.rdata     = r_reg.rdata;
  assign bus.rvalid    = r_reg.rvalid;
  assign bus.irq       = r_reg.irq;
  assign usb_in_ready  = r_reg.in_ready;
  assign usb_out_valid = r_reg.out_valid;
  assign usb_out_data  = r_reg.out_data;

endmodule

/* File: hdl/dcd_host.sv */
`timescale 1ns/1ps
module dcd_host (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt.
  output logic             irq,
  // Device side.
  dcd_if.host              dev
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_WAIT} dcd_st_e;

  typedef struct packed {
    dcd_st_e     st;
    logic        a_wr;
    logic [4:0]  a_off;
    logic [31:0] hrdata;
    logic        op_wr;
    logic        op_pin;
    logic        bus8;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        irq;
    logic        cs;
    logic        rd;
    logic        wr;
    logic        ack;
  } dcd_host_s;

  dcd_host_s r_reg;
  dcd_host_s r_next;
  logic      busy;
  logic      wr_en;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    busy   = (r_reg.st != ST_IDLE);
    wr_en  = r_reg.a_wr;
    // Address phase capture; read data is ready for the data phase.
    r_next.a_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      r_next.a_wr  = hwrite;
      r_next.a_off = haddr[4:0];
      if (haddr[4:0] == dcd_pkg::H_CTRL) begin
        r_next.hrdata = {28'h0, r_reg.bus8, r_reg.op_pin,
                         r_reg.op_wr, busy};
      end else if (haddr[4:0] == dcd_pkg::H_ADDR) begin
        r_next.hrdata = {24'h0, r_reg.addr};
      end else if (haddr[4:0] == dcd_pkg::H_WDATA) begin
        r_next.hrdata = {16'h0, r_reg.wdata};
      end else if (haddr[4:0] == dcd_pkg::H_RDATA) begin
        r_next.hrdata = {16'h0, r_reg.rdata};
      end else if (haddr[4:0] == dcd_pkg::H_ISTAT) begin
        r_next.hrdata = {30'h0, r_reg.istat};
      end else if (haddr[4:0] == dcd_pkg::H_IMASK) begin
        r_next.hrdata = {30'h0, r_reg.imask};
      end else begin
        r_next.hrdata = 32'h0000_0000;
      end
    end
    // Data phase writes; status clears before events so events win.
    if (wr_en) begin
      if (r_reg.a_off == dcd_pkg::H_CTRL) begin
        if (!busy) begin
          r_next.op_wr  = hwdata[dcd_pkg::HC_WRITE];
          r_next.op_pin = hwdata[dcd_pkg::HC_PIN];
          r_next.bus8   = hwdata[dcd_pkg::HC_BUS8];
        end
      end else if (r_reg.a_off == dcd_pkg::H_ADDR) begin
        r_next.addr = hwdata[7:0];
      end else if (r_reg.a_off == dcd_pkg::H_WDATA) begin
        r_next.wdata = hwdata[15:0];
      end else if (r_reg.a_off == dcd_pkg::H_ISTAT) begin
        r_next.istat = r_reg.istat & ~hwdata[1:0];
      end else if (r_reg.a_off == dcd_pkg::H_IMASK) begin
        r_next.imask = hwdata[1:0];
      end
    end
    // One device access: strobe, hold a cycle, then a settling cycle.
    r_next.cs  = 1'b0;
    r_next.rd  = 1'b0;
    r_next.wr  = 1'b0;
    r_next.ack = 1'b0;
    case (r_reg.st)
      ST_IDLE: begin
        if (wr_en && r_reg.a_off == dcd_pkg::H_CTRL &&
            hwdata[dcd_pkg::HC_START]) begin
          r_next.ack = hwdata[dcd_pkg::HC_PIN];
          r_next.cs  = ~hwdata[dcd_pkg::HC_PIN];
          r_next.rd  = ~hwdata[dcd_pkg::HC_PIN] &
                       ~hwdata[dcd_pkg::HC_WRITE];
          r_next.wr  = ~hwdata[dcd_pkg::HC_PIN] &
                       hwdata[dcd_pkg::HC_WRITE];
          r_next.st  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        r_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        // The settling cycle keeps counter and level reads exact.
        if (dev.rvalid) begin
          r_next.rdata = dev.rdata;
        end
        r_next.istat[dcd_pkg::HI_DONE] = 1'b1;
        r_next.st = ST_IDLE;
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
    if (dev.irq) begin
      r_next.istat[dcd_pkg::HI_DEV] = 1'b1;
    end
    r_next.irq = |(r_next.istat & r_next.imask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops or constant zero wait and OKAY.
  assign hrdata              = r_reg.hrdata;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign irq                 = r_reg.irq;
  assign dev.cs              = r_reg.cs;
  assign dev.rd              = r_reg.rd;
  assign dev.wr              = r_reg.wr;
  assign dev.acknowledge_pin = r_reg.ack;
  assign dev.bus8            = r_reg.bus8;
  assign dev.addr            = r_reg.addr;
  assign dev.wdata           = r_reg.wdata;

endmodule

/* File: pkg/dcd_if.sv */
`timescale 1ns/1ps
interface dcd_if (
  input wire logic hclk
);
  logic        cs;
  logic        rd;
  logic        wr;
  logic        acknowledge_pin;
  logic        bus8;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        irq;

  modport dev (
    input  cs, rd, wr, acknowledge_pin, bus8, addr, wdata,
    output rdata, rvalid, irq
  );
  modport host (
    output cs, rd, wr, acknowledge_pin, bus8, addr, wdata,
    input  rdata, rvalid, irq
  );
endinterface

/* File: pkg/dcd_pkg.sv */
// Notes on behaviour
// - Read direction: level shows valid FIFO bytes.
// - Write direction: level shows free FIFO bytes.
// - Wait one cycle before sampling free level.
// - Read multi-byte values high byte first.
// - Count mode loads 32-bit byte length.
// - Count mode decrements counter per byte moved.
// - Load byte count before setting start bit.
// - Count mode ends transfer at zero count.
// - Free-running mode increments counter per byte.
// - Counter wrap sets overflow flag.
// - After overflow counter wraps and keeps counting.
// - Wait one cycle before reading counter.
// - Register acknowledge: port reads pop FIFO bytes.
// - Set read direction before reading ports.
// - 8-bit mode: either port gives next byte.
// - Acknowledge mode: pin or register access.
// - Direction bit: 0 into FIFO, 1 out.
// - Counter clear zeroes counter unless running.
package dcd_pkg;

  // ----------------------------------------------------------------
  // Device side
  // ----------------------------------------------------------------
  localparam int          FIFO_DEPTH  = 4096;
  localparam logic [12:0] FIFO_FULL   = 13'h1000;
  localparam logic [7:0]  A_CFG       = 8'h61;
  localparam logic [7:0]  A_CTRL      = 8'h62;
  localparam logic [7:0]  A_LVL_H     = 8'h64;
  localparam logic [7:0]  A_LVL_L     = 8'h65;
  localparam logic [7:0]  A_CNT3      = 8'h68;
  localparam logic [7:0]  A_CNT2      = 8'h69;
  localparam logic [7:0]  A_CNT1      = 8'h6a;
  localparam logic [7:0]  A_CNT0      = 8'h6b;
  localparam logic [7:0]  A_RD_EVEN   = 8'h6c;
  localparam logic [7:0]  A_RD_ODD    = 8'h6d;
  localparam logic [7:0]  A_ISTAT     = 8'h70;
  localparam int          CFG_FREE    = 7;
  localparam int          CFG_ACKREG  = 6;
  localparam int          CTL_RUN     = 7;
  localparam int          CTL_CLR     = 4;
  localparam int          CTL_DIR     = 3;
  localparam int          CTL_STOP    = 1;
  localparam int          CTL_GO      = 0;
  localparam int          IST_CMP     = 0;
  localparam int          IST_OVF     = 1;
  localparam logic [31:0] CNT_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Controller side, byte addresses of word registers
  // ----------------------------------------------------------------
  localparam logic [4:0]  H_CTRL      = 5'h00;
  localparam logic [4:0]  H_ADDR      = 5'h04;
  localparam logic [4:0]  H_WDATA     = 5'h08;
  localparam logic [4:0]  H_RDATA     = 5'h0c;
  localparam logic [4:0]  H_ISTAT     = 5'h10;
  localparam logic [4:0]  H_IMASK     = 5'h14;
  localparam int          HC_START    = 0;
  localparam int          HC_WRITE    = 1;
  localparam int          HC_PIN      = 2;
  localparam int          HC_BUS8     = 3;
  localparam int          HI_DONE     = 0;
  localparam int          HI_DEV      = 1;

endpackage

/* File: tb/dcd_assertions.sv */
`timescale 1ns/1ps
module dcd_assertions (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Link signals.
  input wire logic        cs,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic        acknowledge_pin,
  input wire logic        bus8,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // Link checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A read strobe and the single answer pulse it earns.
  sequence s_rd;
    cs && rd;
  endsequence
  sequence s_ans;
    rvalid ##1 !rvalid;
  endsequence
  // A read of the high level byte, answered now.
  sequence s_lvl;
    rvalid && $past(rd && addr == dcd_pkg::A_LVL_H);
  endsequence

  property p_rd_ans;
    s_rd |=> s_ans;
  endproperty
  property p_cause;
    rvalid |-> $past(rd || acknowledge_pin);
  endproperty
  property p_hold;
    !rvalid |-> $stable(rdata);
  endproperty
  property p_lvl13;
    s_lvl |-> rdata[15:5] == 11'h000;
  endproperty
  property p_free;
    s_lvl |-> rdata[7:0] <= 8'h10;
  endproperty
  property p_port8;
    rvalid && $past(rd && bus8) |-> rdata[15:8] == 8'h00;
  endproperty
  property p_regb;
    rvalid && $past(rd && addr[7:1] != 7'h36) |-> rdata[15:8] == 8'h00;
  endproperty
  property p_irq_clr;
    $fell(irq) |-> $past(cs && wr && addr == dcd_pkg::A_ISTAT)
      || $past(cs && wr && addr == dcd_pkg::A_ISTAT, 2);
  endproperty

  a_rd_ans: assert property (p_rd_ans)
    else $error("read strobe without single answer pulse");
  a_cause: assert property (p_cause)
    else $error("answer pulse without access");
  a_hold: assert property (p_hold)
    else $error("read data changed between answers");
  a_lvl13: assert property (p_lvl13)
    else $error("level field wider than thirteen bits");
  a_free: assert property (p_free)
    else $error("level above fifo depth");
  a_port8: assert property (p_port8)
    else $error("eight bit access returned upper byte");
  a_regb: assert property (p_regb)
    else $error("register read upper byte not zero");
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt dropped without status clear");
endmodule

/* File: tb/dma_counter_and_data_port_test.sv */
`timescale 1ns/1ps
module dma_counter_and_data_port_test;
  // ----------------------------------------------------------------
  // Signals, clock and design
  // ----------------------------------------------------------------
  logic        hclk = 1'b0;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        usb_in_valid;
  logic [7:0]  usb_in_data;
  logic        usb_in_ready;
  logic        usb_out_valid;
  logic [7:0]  usb_out_data;
  logic        usb_out_ready;
  logic        b8;
  logic [31:0] r;
  int          bad_count = 0;
  int          comparisons = 0;

  // Clock at 100 MHz.
  always #5 hclk = ~hclk;

  dcd_if dcd_if_inst (.hclk(hclk));
  dcd_dev dcd_dev_inst (.hclk(hclk), .hresetn(hresetn), .bus(dcd_if_inst),
    .usb_in_valid(usb_in_valid), .usb_in_data(usb_in_data),
    .usb_in_ready(usb_in_ready), .usb_out_valid(usb_out_valid),
    .usb_out_data(usb_out_data), .usb_out_ready(usb_out_ready));
  dcd_host dcd_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .dev(dcd_if_inst));
  dcd_assertions dcd_assertions_inst (.hclk(hclk), .hresetn(hresetn),
    .cs(dcd_if_inst.cs), .rd(dcd_if_inst.rd), .wr(dcd_if_inst.wr),
    .acknowledge_pin(dcd_if_inst.acknowledge_pin),
    .bus8(dcd_if_inst.bus8), .addr(dcd_if_inst.addr),
    .wdata(dcd_if_inst.wdata), .rdata(dcd_if_inst.rdata),
    .rvalid(dcd_if_inst.rvalid), .irq(dcd_if_inst.irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run.
  task automatic summarize();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One single AHB transfer, address phase then data phase.
  task automatic ahb(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= {27'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // One device access through the controller, waiting for done.
  task automatic dev(input logic pin, input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    logic [31:0] s;
    int          n;
    ahb(1'b1, dcd_pkg::H_ADDR, {24'h0, a}, s);
    ahb(1'b1, dcd_pkg::H_WDATA, {16'h0, d}, s);
    ahb(1'b1, dcd_pkg::H_CTRL, {28'h0, b8, pin, w, 1'b1}, s);
    s = 32'h0;
    n = 0;
    while (s[0] !== 1'b1 && n < 50) begin
      ahb(1'b0, dcd_pkg::H_ISTAT, 32'h0, s);
      n++;
    end
    // A poll limit that runs out counts as a mismatch.
    chk({31'h0, s[0]}, 32'h1);
    ahb(1'b1, dcd_pkg::H_ISTAT, 32'h1, s);
    ahb(1'b0, dcd_pkg::H_RDATA, 32'h0, q);
  endtask

  task automatic dw(input logic [7:0] a, input logic [15:0] d);
    dev(1'b0, 1'b1, a, d, r);
  endtask

  task automatic dr(input logic [7:0] a, input logic [15:0] e);
    dev(1'b0, 1'b0, a, 16'h0, r);
    chk(r, {16'h0, e});
  endtask

  // Counter bytes, highest first.
  task automatic wcnt(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      dw(dcd_pkg::A_CNT3 + 8'(i), {8'h0, v[31-8*i -: 8]});
    end
  endtask

  task automatic cnt(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      dr(dcd_pkg::A_CNT3 + 8'(i), {8'h0, v[31-8*i -: 8]});
    end
  endtask

  // Pushes n bytes from b upward into the FIFO.
  task automatic fill(input int n, input logic [7:0] b);
    usb_in_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      usb_in_data <= b + 8'(i);
      do @(posedge hclk); while (usb_in_ready !== 1'b1);
    end
    usb_in_valid <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Watchdog that cuts a hang short.
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  // Main sequence.
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    usb_in_valid = 1'b0;
    usb_in_data = 8'h00;
    usb_out_ready = 1'b0;
    b8 = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 5'h18, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    cnt(32'h0);
    dr(dcd_pkg::A_LVL_H, 16'h10);
    dr(dcd_pkg::A_LVL_L, 16'h00);
    // Count mode, register acknowledge, read direction.
    dw(dcd_pkg::A_CFG, 16'h40);
    dw(dcd_pkg::A_CTRL, 16'h08);
    fill(5, 8'ha0);
    dr(dcd_pkg::A_LVL_H, 16'h00);
    dr(dcd_pkg::A_LVL_L, 16'h05);
    wcnt(32'h4);
    dw(dcd_pkg::A_CTRL, 16'h09);
    dr(dcd_pkg::A_CTRL, 16'h88);
    b8 = 1'b1;
    dr(dcd_pkg::A_RD_EVEN, 16'ha0);
    dr(dcd_pkg::A_RD_ODD, 16'ha1);
    cnt(32'h2);
    b8 = 1'b0;
    dr(dcd_pkg::A_RD_EVEN, 16'ha3a2);
    dr(dcd_pkg::A_CTRL, 16'h08);
    cnt(32'h0);
    dr(dcd_pkg::A_LVL_H, 16'h00);
    dr(dcd_pkg::A_LVL_L, 16'h01);
    dr(dcd_pkg::A_ISTAT, 16'h01);
    // Host interrupt masked, unmasked, then cleared.
    ahb(1'b0, dcd_pkg::H_ISTAT, 32'h0, r);
    chk(r, 32'h2);
    chk({31'h0, irq}, 32'h0);
    ahb(1'b1, dcd_pkg::H_IMASK, 32'h2, r);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    dw(dcd_pkg::A_ISTAT, 16'h01);
    ahb(1'b1, dcd_pkg::H_ISTAT, 32'h2, r);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    // Free-running wrap past all ones.
    wcnt(32'hffff_fffe);
    dw(dcd_pkg::A_CFG, 16'hc0);
    dw(dcd_pkg::A_CTRL, 16'h09);
    fill(3, 8'ha5);
    dr(dcd_pkg::A_RD_EVEN, 16'ha5a4);
    cnt(32'h0);
    dr(dcd_pkg::A_ISTAT, 16'h02);
    b8 = 1'b1;
    dr(dcd_pkg::A_RD_ODD, 16'ha6);
    cnt(32'h1);
    dw(dcd_pkg::A_CTRL, 16'h18);
    cnt(32'h1);
    dw(dcd_pkg::A_CTRL, 16'h0a);
    dw(dcd_pkg::A_CTRL, 16'h18);
    cnt(32'h0);
    dw(dcd_pkg::A_ISTAT, 16'h03);
    // Pin acknowledge mode.
    dw(dcd_pkg::A_CFG, 16'h00);
    fill(1, 8'ha8);
    wcnt(32'h2);
    dw(dcd_pkg::A_CTRL, 16'h09);
    dr(dcd_pkg::A_RD_EVEN, 16'h00);
    b8 = 1'b0;
    dev(1'b1, 1'b0, 8'h00, 16'h0, r);
    chk(r, 32'ha8a7);
    cnt(32'h0);
    // Write direction by pin, far side stalled.
    dw(dcd_pkg::A_CTRL, 16'h00);
    dr(dcd_pkg::A_LVL_H, 16'h10);
    wcnt(32'h2);
    dw(dcd_pkg::A_CTRL, 16'h01);
    dev(1'b1, 1'b1, 8'h00, 16'hbbaa, r);
    // Controller registers read back what the last access used, and the interrupt mask.
    ahb(1'b0, dcd_pkg::H_CTRL, 32'h0, r);
    chk(r, 32'h6);
    ahb(1'b0, dcd_pkg::H_WDATA, 32'h0, r);
    chk(r, 32'hbbaa);
    ahb(1'b0, dcd_pkg::H_IMASK, 32'h0, r);
    chk(r, 32'h2);
    dr(dcd_pkg::A_LVL_H, 16'h0f);
    dr(dcd_pkg::A_LVL_L, 16'hfe);
    cnt(32'h0);
    usb_out_ready <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      do @(posedge hclk); while (usb_out_valid !== 1'b1);
      chk({24'h0, usb_out_data}, 32'haa + 32'(i) * 32'h11);
    end
    usb_out_ready <= 1'b0;
    summarize();
  end
endmodule
